//--- hw/sep_map.vh
`ifndef SEP_MAP_VH
`define SEP_MAP_VH
// ==================================================
// opcodes
`define SEP_OP_READ    8'h03
`define SEP_OP_RDSTAT  8'h05
`define SEP_OP_WRSTAT  8'h01
`define SEP_OP_WRITE   8'h02
`define SEP_OP_SETL    8'h06
`define SEP_OP_CLRL    8'h04
// ==================================================
// status register fields
`define SEP_ST_GUARD   7
`define SEP_ST_UPPER   3
`define SEP_ST_LOWER   2
`define SEP_ST_LATCH   1
`define SEP_ST_BUSY    0
`define SEP_ST_WMASK   8'h8c
`define SEP_ST_RESET   8'h00
// ==================================================
// protected region starts (13-bit array)
`define SEP_PROT_Q     13'h1800
`define SEP_PROT_H     13'h1000
`define SEP_PROT_F     13'h0000
// ==================================================
// timing
`define SEP_CLK_HZ     10000000
`define SEP_TWC_US     5000
`define SEP_TWC_CYC    ((`SEP_TWC_US * (`SEP_CLK_HZ / 1000000)))
`define SEP_TPUR_US    1000
`endif

//--- hw/sep_sync.v
`timescale 1ns/10ps
// ==================================================
// two-flop synchroniser, one per bit
module sep_sync
#(
    parameter W = 4
)
(
    input  wire         clk_i,
    input  wire         ce_i,
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] meta;
    reg [W-1:0] sync;
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1)
        begin : bitsync
            always @(posedge clk_i)
            begin
                if (ce_i)
                begin
                    meta[g] <= d_i[g];
                    sync[g] <= meta[g];
                end
            end
        end
    endgenerate
    assign q_o = sync;
endmodule

//--- hw/sep_core.v
// What this block does
// - serial input sampled on rising serial clock edges while selected and not paused, modes 0,0 and 1,1.
// - serial output changes on falling serial clock edges.
// - chip select high: output high impedance, standby unless a write runs.
// - guard pin high allows writes; low with guard enable refuses status writes.
// - 8-bit instruction register; only six opcodes acted upon, others ignored.
// - read 03h, status read 05h, status write 01h, msb first.
// - write 02h, set latch 06h, clear latch 04h.
// - status layout guard enable, three zeros, upper, lower, latch, busy.
// - busy reads 1 during self-timed write; host writes cannot change it.
// - set-latch sets, clear-latch clears the write latch.
// - protect bits loaded only by status write, kept across power cycles.
// - protect bits select none, 1800-1FFF, 1000-1FFF or whole array.
// - hardware protection when pin low and guard enable set.
// - latch clear blocks everything; protected blocks never writable.
// - latch cleared after power-up.
// - no array location inside protected region is ever programmed.
// - while paused, output high impedance and serial input ignored.
// - valid write starts timer at chip select rise; only status read accepted.
// - write cycle completion clears the write latch.
// - status write changes only bits 2, 3 and 7.
`timescale 1ns/10ps
`include "sep_map.vh"
module sep_core
#(
    parameter TWC_CYC = `SEP_TWC_CYC
)
(
    // clock, reset, enable
    input  wire        sys_clk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    // serial pins
    input  wire        sclk_i,
    input  wire        cs_n_i,
    input  wire        sdi_i,
    input  wire        pause_n_i,
    input  wire        guard_n_i,
    output wire        sdo_o,
    output wire        sdo_oe_n_o,
    // nonvolatile protect image at power-up
    input  wire [2:0]  nv_bits_i,
    // array programming request to the data path
    output reg         prog_start_o,
    output reg  [12:0] prog_addr_o,
    output reg  [7:0]  prog_data_o,
    output reg  [2:0]  nv_store_o,
    output wire [7:0]  status_o
);
    // ==================================================
    // synchronised pins
    wire [4:0] pins;
    sep_sync #(.W(5)) u_sync
    (
        .clk_i (sys_clk_i),
        .ce_i  (ce_i),
        .d_i   ({sclk_i, cs_n_i, sdi_i, pause_n_i, guard_n_i}),
        .q_o   (pins)
    );
    wire sck_s   = pins[4];
    wire cs_n_s  = pins[3];
    wire sdi_s   = pins[2];
    wire pause_s = pins[1];
    wire guard_s = pins[0];

    reg        sck_d;
    reg        cs_d;
    reg        paused;
    wire       active = ~cs_n_s & ~paused;
    wire       rise   = sck_s & ~sck_d & active;
    wire       fall   = ~sck_s & sck_d & active;
    wire       cs_up  = cs_n_s & ~cs_d;
    wire       cs_dn  = ~cs_n_s & cs_d;

    // ==================================================
    // states
    localparam [4:0] S_OP    = 5'b00001;
    localparam [4:0] S_ADDR  = 5'b00010;
    localparam [4:0] S_DATA  = 5'b00100;
    localparam [4:0] S_OUT   = 5'b01000;
    localparam [4:0] S_SKIP  = 5'b10000;

    reg [4:0]  state;
    reg [7:0]  instr;
    reg [7:0]  shreg;
    reg [4:0]  bitcnt;
    reg [15:0] addr;
    reg [7:0]  wdata;
    reg        data_seen;
    reg        pend_set;
    reg        pend_clr;
    reg        pend_stat;
    reg [7:0]  stat_new;
    reg        pend_arr;
    reg        guard_enable_bit;
    reg        upper_protect_bit;
    reg        lower_protect_bit;
    reg        write_latch_bit;
    reg        busy;
    reg [31:0] wcnt;
    reg        is_stat_prog;
    reg [7:0]  outsh;
    reg        sdo_q;
    reg        drive;
    reg        nv_loaded;
    reg [7:0]  next_shreg;

    wire [7:0] status = {guard_enable_bit, 3'b000, upper_protect_bit,
                         lower_protect_bit, write_latch_bit, busy};
    assign status_o = status;

    wire hw_prot = ~guard_s & guard_enable_bit;

    reg in_prot;
    always @*
    begin
        case ({upper_protect_bit, lower_protect_bit})
            2'b01:   in_prot = addr[12:0] >= `SEP_PROT_Q;
            2'b10:   in_prot = addr[12:0] >= `SEP_PROT_H;
            2'b11:   in_prot = addr[12:0] >= `SEP_PROT_F;
            default: in_prot = 1'b0;
        endcase
    end

    wire arr_ok  = write_latch_bit & ~in_prot;
    wire stat_ok = write_latch_bit & ~hw_prot;

    always @*
    begin
        next_shreg = {shreg[6:0], sdi_s};
    end

    assign sdo_o      = sdo_q;
    assign sdo_oe_n_o = ~(drive & active);

    // ==================================================
    // main sequencer
    always @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            sck_d             <= 1'b0;
            cs_d              <= 1'b1;
            paused            <= 1'b0;
            state             <= S_OP;
            instr             <= 8'h00;
            shreg             <= 8'h00;
            bitcnt            <= 5'h00;
            addr              <= 16'h0000;
            wdata             <= 8'h00;
            data_seen         <= 1'b0;
            pend_set          <= 1'b0;
            pend_clr          <= 1'b0;
            pend_stat         <= 1'b0;
            stat_new          <= 8'h00;
            pend_arr          <= 1'b0;
            guard_enable_bit  <= 1'b0;
            upper_protect_bit <= 1'b0;
            lower_protect_bit <= 1'b0;
            write_latch_bit   <= 1'b0;
            busy              <= 1'b0;
            wcnt              <= 32'h0;
            is_stat_prog      <= 1'b0;
            outsh             <= 8'h00;
            sdo_q             <= 1'b0;
            drive             <= 1'b0;
            nv_loaded         <= 1'b0;
            prog_start_o      <= 1'b0;
            prog_addr_o       <= 13'h0000;
            prog_data_o       <= 8'h00;
            nv_store_o        <= 3'b000;
        end
        else if (ce_i)
        begin
            sck_d        <= sck_s;
            cs_d         <= cs_n_s;
            prog_start_o <= 1'b0;
            // protect bits restored from storage after reset
            if (!nv_loaded)
            begin
                nv_loaded         <= 1'b1;
                guard_enable_bit  <= nv_bits_i[2];
                upper_protect_bit <= nv_bits_i[1];
                lower_protect_bit <= nv_bits_i[0];
            end
            // pause changes only honoured while clock is low
            if (~cs_n_s & ~sck_s)
                paused <= ~pause_s;
            else if (cs_n_s)
                paused <= 1'b0;

            if (cs_dn)
            begin
                state     <= S_OP;
                bitcnt    <= 5'h00;
                drive     <= 1'b0;
                data_seen <= 1'b0;
            end

            if (rise)
            begin
                shreg  <= next_shreg;
                bitcnt <= bitcnt + 5'h01;
                case (state)
                    S_OP:
                    begin
                        if (bitcnt == 5'h07)
                        begin
                            instr  <= next_shreg;
                            bitcnt <= 5'h00;
                            state  <= S_SKIP;
                            // busy ignores all but status read
                            if (!busy || next_shreg == `SEP_OP_RDSTAT)
                            begin
                                case (next_shreg)
                                    `SEP_OP_SETL:
                                        pend_set <= 1'b1;
                                    `SEP_OP_CLRL:
                                        pend_clr <= 1'b1;
                                    `SEP_OP_RDSTAT:
                                    begin
                                        state <= S_OUT;
                                        outsh <= status;
                                        drive <= 1'b1;
                                    end
                                    `SEP_OP_WRSTAT:
                                        state <= S_DATA;
                                    `SEP_OP_READ,
                                    `SEP_OP_WRITE:
                                        state <= S_ADDR;
                                    default:
                                        state <= S_SKIP;
                                endcase
                            end
                        end
                    end
                    S_ADDR:
                    begin
                        addr <= {addr[14:0], sdi_s};
                        if (bitcnt == 5'h0f)
                        begin
                            bitcnt <= 5'h00;
                            state  <= (instr == `SEP_OP_WRITE) ? S_DATA : S_SKIP;
                        end
                    end
                    S_DATA:
                    begin
                        if (bitcnt == 5'h07)
                        begin
                            bitcnt    <= 5'h00;
                            wdata     <= next_shreg;
                            data_seen <= 1'b1;
                            if (instr == `SEP_OP_WRSTAT)
                            begin
                                stat_new  <= next_shreg;
                                pend_stat <= stat_ok;
                                state     <= S_SKIP;
                            end
                            else
                                pend_arr  <= 1'b1;
                        end
                    end
                    S_OUT:
                        bitcnt <= 5'h00;
                    S_SKIP:
                        bitcnt <= 5'h00;
                    default:
                        state <= S_SKIP;
                endcase
            end

            if (fall && state == S_OUT)
            begin
                sdo_q <= outsh[7];
                outsh <= {outsh[6:0], outsh[7]};
            end

            // guard dropping mid-frame kills a pending status write
            if (pend_stat && !stat_ok)
                pend_stat <= 1'b0;

            // ==================================================
            // frame end actions
            if (cs_up)
            begin
                drive    <= 1'b0;
                state    <= S_OP;
                bitcnt   <= 5'h00;
                pend_set <= 1'b0;
                pend_clr <= 1'b0;
                pend_stat <= 1'b0;
                pend_arr <= 1'b0;
                // partial bytes dropped with no state change
                if (state != S_OP || bitcnt == 5'h00)
                begin
                    // latch effective at chip select rise
                    if (pend_set)
                        write_latch_bit <= 1'b1;
                    else if (pend_clr)
                        write_latch_bit <= 1'b0;
                    else if (pend_stat && stat_ok)
                    begin
                        guard_enable_bit  <= stat_new[`SEP_ST_GUARD];
                        upper_protect_bit <= stat_new[`SEP_ST_UPPER];
                        lower_protect_bit <= stat_new[`SEP_ST_LOWER];
                        nv_store_o <= {stat_new[`SEP_ST_GUARD], stat_new[`SEP_ST_UPPER],
                                       stat_new[`SEP_ST_LOWER]};
                        busy         <= 1'b1;
                        is_stat_prog <= 1'b1;
                        wcnt         <= 32'h0;
                    end
                    else if (pend_arr && data_seen && arr_ok && bitcnt == 5'h00)
                    begin
                        busy         <= 1'b1;
                        is_stat_prog <= 1'b0;
                        wcnt         <= 32'h0;
                        prog_start_o <= 1'b1;
                        prog_addr_o  <= addr[12:0];
                        prog_data_o  <= wdata;
                    end
                end
            end

            // busy held for the write cycle time
            if (busy)
            begin
                wcnt <= wcnt + 32'h1;
                if (wcnt == TWC_CYC - 1)
                begin
                    busy <= 1'b0;
                    write_latch_bit <= 1'b0;
                end
            end
        end
    end
endmodule

//--- verification/sep_core_sva.sv
`timescale 1ns/10ps
// ==================================================
// checker on the core ports
module sep_core_sva
#(
    parameter TWC_CYC = 50000
)
(
    input logic        sys_clk_i,
    input logic        rst_i,
    input logic        cs_n_i,
    input logic        sclk_i,
    input logic        pause_n_i,
    input logic        guard_n_i,
    input logic        sdo_oe_n_o,
    input logic        prog_start_o,
    input logic [12:0] prog_addr_o,
    input logic [7:0]  status_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    int busy_cnt = 0;
    // counts busy cycles so a stuck self-timed write is seen
    always @(posedge sys_clk_i)
        busy_cnt <= (rst_i || !status_o[0]) ? 0 : busy_cnt + 1;
    function automatic logic prot(input logic [1:0] bp, input logic [12:0] a);
        return bp == 2'h3 || (bp == 2'h2 && a >= 13'h1000) || (bp == 2'h1 && a >= 13'h1800);
    endfunction
    a_idle_cs_hiz: assert property (cs_n_i [*4] |-> sdo_oe_n_o)
        else $error("output driven while deselected");
    a_pause_hiz: assert property ((!pause_n_i && !sclk_i) [*6] |-> sdo_oe_n_o)
        else $error("output driven while paused");
    a_status_zeros: assert property (status_o[6:4] == 3'h0)
        else $error("status bits 6 to 4 not zero");
    a_prog_latch: assert property (prog_start_o |-> status_o[1])
        else $error("program start without write latch");
    a_prog_region: assert property (prog_start_o |-> !prot(status_o[3:2], prog_addr_o))
        else $error("program start inside protected region");
    a_prog_busy: assert property (prog_start_o |-> ##[0:3] status_o[0])
        else $error("busy not raised after program start");
    a_done_clears: assert property ($fell(status_o[0]) |-> ##[0:1] !status_o[1])
        else $error("write latch kept after write cycle");
    a_busy_bound: assert property (busy_cnt <= TWC_CYC + 3)
        else $error("busy held too long");
    a_latch_at_cs: assert property ($rose(status_o[1]) |-> cs_n_i && $past(cs_n_i, 2))
        else $error("write latch set before chip select rise");
    a_guard_keeps: assert property (!guard_n_i && !$past(guard_n_i, 4) && status_o[7] |=> $stable({status_o[7], status_o[3:2]}))
        else $error("status changed under hardware protection");
endmodule
bind sep_core sep_core_sva #(.TWC_CYC(TWC_CYC)) u_sva (
    .sys_clk_i    (sys_clk_i),
    .rst_i        (rst_i),
    .cs_n_i       (cs_n_i),
    .sclk_i       (sclk_i),
    .pause_n_i    (pause_n_i),
    .guard_n_i    (guard_n_i),
    .sdo_oe_n_o   (sdo_oe_n_o),
    .prog_start_o (prog_start_o),
    .prog_addr_o  (prog_addr_o),
    .status_o     (status_o)
);

//--- verification/sep_host_model.sv
`timescale 1ns/10ps
// ==================================================
// host serial master, half period of four system clocks
module sep_host_model
(
    // clock
    input  logic clk_i,
    // device side
    input  logic sdo_i,
    input  logic sdo_oe_n_i,
    output logic sclk_o    = 1'b0,
    output logic cs_n_o    = 1'b1,
    output logic sdi_o     = 1'b0,
    output logic pause_n_o = 1'b1
);
    // a released output reads as unknown so it matches only an unknown expected bit
    task automatic frame(input logic cpol, input int n, input logic [31:0] tx, input int pa,
                         output logic [7:0] rx);
        rx = 8'h00;
        @(posedge clk_i);
        sclk_o <= cpol;
        repeat (4) @(posedge clk_i);
        cs_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < n; i++)
        begin
            sclk_o <= 1'b0;
            sdi_o  <= tx[n-1-i];
            repeat (4) @(posedge clk_i);
            if (i == pa)
            begin
                pause_n_o <= 1'b0;
                repeat (4) @(posedge clk_i);
                // stray bit and clock pulse must be ignored
                sdi_o  <= ~tx[n-1-i];
                sclk_o <= 1'b1;
                repeat (4) @(posedge clk_i);
                sclk_o <= 1'b0;
                repeat (8) @(posedge clk_i);
                sdi_o     <= tx[n-1-i];
                pause_n_o <= 1'b1;
                repeat (4) @(posedge clk_i);
            end
            sclk_o <= 1'b1;
            rx = {rx[6:0], sdo_oe_n_i ? 1'bx : sdo_i};
            repeat (4) @(posedge clk_i);
        end
        sclk_o <= cpol;
        repeat (4) @(posedge clk_i);
        cs_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
endmodule

//--- verification/serial_eeprom_command_protect_tb.sv
`timescale 1ns/10ps
// ==================================================
// command and protection bench
module serial_eeprom_command_protect_tb;
    localparam TWC = 400;
    // power-up to first read, 1 ms of system clocks
    localparam TPUR = 10000;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        guard_n = 1'b1;
    logic [2:0]  nv_bits = 3'h0;
    logic        cpol = 1'b0;
    logic [7:0]  rx;
    logic [12:0] addrs [4] = '{13'h0fff, 13'h1000, 13'h17ff, 13'h1800};
    logic [7:0]  bads [4] = '{8'h00, 8'hff, 8'h07, 8'h86};
    wire         sclk, cs_n, sdi, pause_n, sdo, sdo_oe_n, prog_start;
    wire  [12:0] prog_addr;
    wire  [7:0]  status;
    int          err_total = 0;
    int          comparisons = 0;
    int          prog_cnt = 0;
    int          n0;

    always #50 clk = ~clk;
    always @(posedge clk)
        if (prog_start)
            prog_cnt <= prog_cnt + 1;

    sep_core #(.TWC_CYC(TWC)) u_dut (
        .sys_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
        .pause_n_i(pause_n), .guard_n_i(guard_n), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n),
        .nv_bits_i(nv_bits), .prog_start_o(prog_start), .prog_addr_o(prog_addr),
        .prog_data_o(), .nv_store_o(), .status_o(status));
    sep_host_model u_host (
        .clk_i(clk), .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n), .sclk_o(sclk), .cs_n_o(cs_n),
        .sdi_o(sdi), .pause_n_o(pause_n));

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic send(input int n, input logic [31:0] tx, input int pa = -1);
        u_host.frame(cpol, n, tx, pa, rx);
    endtask
    task automatic status_read_instr(input logic [7:0] exp, input int pa = -1);
        send(16, 32'h0500, pa);
        check("status", {8'h00, exp}, {8'h00, rx});
    endtask
    task automatic settle;
        repeat (TWC + 40) @(posedge clk);
    endtask
    task automatic wr(input logic [12:0] a);
        send(8, 32'h06);
        send(32, {8'h02, 3'h0, a, 8'h5a});
        settle;
    endtask
    task automatic status_write_instr(input logic [7:0] v);
        send(8, 32'h06);
        send(16, {16'h0, 8'h01, v});
    endtask
    task automatic do_reset(input logic [2:0] nv);
        nv_bits <= nv;
        rst     <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        repeat (TPUR) @(posedge clk);
    endtask
    function automatic logic prot(input logic [1:0] bp, input logic [12:0] a);
        return bp == 2'h3 || (bp == 2'h2 && a >= 13'h1000) || (bp == 2'h1 && a >= 13'h1800);
    endfunction

    initial
    begin
        do_reset(3'h0);
        status_read_instr(8'h00);
        cpol = 1'b1;
        send(8, 32'h06);
        status_read_instr(8'h02);
        cpol = 1'b0;
        send(8, 32'h04);
        status_read_instr(8'h00);
        send(32, 32'h03001800);
        send(7, 32'h03);
        status_read_instr(8'h00);
        foreach (bads[i])
        begin
            send(16, {16'h0, bads[i], 8'h00});
            check("no answer", {8'h00, 8'hxx}, {8'h00, rx});
        end
        send(16, 32'h018c);
        status_read_instr(8'h00);
        $display("test opcodes done");
        status_write_instr(8'hff);
        send(16, 32'h0500);
        check("busy", 16'h0003, {8'h00, rx & 8'h03});
        send(16, 32'h0100);
        send(8, 32'h06);
        settle;
        status_read_instr(8'h8c);
        check("nv image", 16'h0007, {13'h0, u_dut.nv_store_o});
        for (int b = 0; b < 4; b++)
        begin
            status_write_instr({4'h0, b[1:0], 2'h0});
            settle;
            status_read_instr({4'h0, b[1:0], 2'h0});
            foreach (addrs[k])
            begin
                n0 = prog_cnt;
                wr(addrs[k]);
                check("programmed", {15'h0, !prot(b[1:0], addrs[k])}, 16'(prog_cnt - n0));
                if (!prot(b[1:0], addrs[k]))
                    check("address", {3'h0, addrs[k]}, {3'h0, prog_addr});
            end
        end
        status_read_instr(8'h0e);
        $display("test protect done");
        status_write_instr(8'h80);
        settle;
        guard_n <= 1'b0;
        status_write_instr(8'h0c);
        settle;
        status_read_instr(8'h82);
        n0 = prog_cnt;
        wr(13'h1fff);
        check("programmed", 16'h0001, 16'(prog_cnt - n0));
        status_read_instr(8'h80);
        guard_n <= 1'b1;
        status_read_instr(8'h80, 4);
        status_read_instr(8'h80, 12);
        $display("test guard done");
        do_reset(3'h5);
        status_read_instr(8'h84);
        $display("test power cycle done");
        stop_test;
    end

    initial
    begin
        repeat (90000) @(posedge clk);
        err_total++;
        stop_test;
    end
endmodule
